/* include/twc_params.svh */
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH
// Summary of operation
// - A nonzero channel action field lets the waveform replace the pin's port function.
// - Waveform reaches a pin only with its direction bit and enable bit set.
// - Enable bit 0 or action 00 keeps the pin in normal port operation.
// - Non-PWM modes: 01 toggles, 10 clears, 11 sets the output on match.
// - Fast PWM: 10 clears on match, sets at TOP; 11 the inverse.
// - PWM action 01 disconnects unless top mode bit set; then A toggles, B reserved.
// - Fast PWM with compare equal TOP ignores the match and acts at TOP.
// - Dual-slope: 10 clears on up-count match, sets on down; 11 reversed.
// - Control bits 3:2 are reserved, read zero and do nothing.
// - Mode is two low bits here plus two high bits elsewhere.
// - Modes 0, 4, 12 count up, TOP FFFF/A/capture, immediate update, overflow at MAX.
// - Modes 1-3 dual-slope TOP 00FF/01FF/03FF, load at TOP, overflow at BOTTOM.
// - Modes 10, 11 dual-slope TOP capture/A, load at TOP, overflow at BOTTOM.
// - Modes 8, 9 dual-slope TOP capture/A, load and overflow at BOTTOM.
// - Fast modes 5-7 fixed TOP, 14/15 capture/A TOP; load and overflow at TOP.
// - The two high mode bits sit at bits 4:3 of the second control register.
// - Dual-slope counting runs from BOTTOM 0000 up to TOP and back down.

// ****************************************
// Register offsets
// ****************************************
`define TWC_ADDR_W 4
`define TWC_OFS_WAVE_CTRL 4'h0
`define TWC_OFS_CTRL_B 4'h1
`define TWC_OFS_PIN_EN 4'h2
`define TWC_OFS_COUNTER 4'h3
`define TWC_OFS_CMP_A 4'h4
`define TWC_OFS_CMP_B 4'h5
`define TWC_OFS_CAPTURE 4'h6
`define TWC_OFS_PIN_DIR 4'h7
`define TWC_OFS_INT_STATUS 4'h8
`define TWC_OFS_INT_MASK 4'h9

// ****************************************
// Field positions and reset values
// ****************************************
`define TWC_ACT_A_HI 7
`define TWC_ACT_A_LO 6
`define TWC_ACT_B_HI 5
`define TWC_ACT_B_LO 4
`define TWC_MODE_LO_HI 1
`define TWC_MODE_LO_LO 0
`define TWC_MODE_HI_HI 4
`define TWC_MODE_HI_LO 3
`define TWC_INT_OVF 0
`define TWC_INT_MATCH_A 1
`define TWC_INT_MATCH_B 2
`define TWC_RST_8 8'h00
`define TWC_RST_16 16'h0000
`define TWC_RST_INT 3'h0

// ****************************************
// Counter limits
// ****************************************
`define TWC_BOTTOM 16'h0000
`define TWC_MAX 16'hFFFF
`define TWC_TOP_8 16'h00FF
`define TWC_TOP_9 16'h01FF
`define TWC_TOP_10 16'h03FF
`endif

/* include/twc_pkg.sv */
package twc_pkg;
  typedef enum logic [1:0] {
    TWC_ACT_OFF = 2'h0,
    TWC_ACT_TOGGLE = 2'h1,
    TWC_ACT_CLEAR = 2'h2,
    TWC_ACT_SET = 2'h3
  } twc_action_type;

  typedef enum logic [1:0] {
    TWC_KIND_NONPWM = 2'h0,
    TWC_KIND_FAST = 2'h1,
    TWC_KIND_DUAL = 2'h2
  } twc_kind_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } twc_bus_req_type;
endpackage

/* rtl/twc_top.sv */
`include "twc_params.svh"
module twc_top #(
  parameter int PINS_PER_CHAN = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire twc_pkg::twc_bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  input wire logic timer_clk_en,
  input wire logic [2*PINS_PER_CHAN-1:0] port_data,
  output logic [2*PINS_PER_CHAN-1:0] pin_out,
  output logic [2*PINS_PER_CHAN-1:0] pin_oe_n,
  output logic chan_a_wave_out,
  output logic chan_b_wave_out,
  output logic irq
);
  import twc_pkg::*;

  localparam int NP = 2 * PINS_PER_CHAN;

  // ****************************************
  // State
  // ****************************************
  logic [7:0] wave_compare_control_r, wave_compare_control_nxt;
  logic [1:0] wave_mode_high_bits_r, wave_mode_high_bits_nxt;
  logic [NP-1:0] pin_enable_control_r, pin_enable_control_nxt;
  logic [NP-1:0] pin_dir_r, pin_dir_nxt;
  logic [15:0] counter_value_r, counter_value_nxt;
  logic [15:0] cmp_a_buf_r, cmp_a_buf_nxt;
  logic [15:0] cmp_b_buf_r, cmp_b_buf_nxt;
  logic [15:0] compare_value_a_r, compare_value_a_nxt;
  logic [15:0] compare_value_b_r, compare_value_b_nxt;
  logic [15:0] capture_value_r, capture_value_nxt;
  logic count_down_r, count_down_nxt;
  logic [2:0] int_status_r, int_status_nxt;
  logic [2:0] int_mask_r, int_mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [1:0] wave_r, wave_nxt;
  logic [NP-1:0] pin_out_r, pin_out_nxt;
  logic [NP-1:0] pin_oe_n_r, pin_oe_n_nxt;

  // ****************************************
  // Mode decode
  // ****************************************
  logic [3:0] wave_mode_sel;
  logic wave_mode_top_bit;
  twc_kind_type kind;
  logic [15:0] top_val;
  logic load_at_top, load_at_bottom, ovf_at_bottom, ovf_at_top;
  logic at_top, at_bottom;
  logic [1:0] match;
  logic [1:0] connected;
  logic [1:0] chan_act [2];
  logic [15:0] chan_cmp [2];

  assign wave_mode_sel = {wave_mode_high_bits_r,
    wave_compare_control_r[`TWC_MODE_LO_HI:`TWC_MODE_LO_LO]};
  assign wave_mode_top_bit = wave_mode_sel[3];
  assign chan_act[0] = wave_compare_control_r[`TWC_ACT_A_HI:`TWC_ACT_A_LO];
  assign chan_act[1] = wave_compare_control_r[`TWC_ACT_B_HI:`TWC_ACT_B_LO];
  assign chan_cmp[0] = compare_value_a_r;
  assign chan_cmp[1] = compare_value_b_r;

  always_comb begin
    kind = TWC_KIND_NONPWM;
    top_val = `TWC_MAX;
    load_at_top = 1'b0;
    load_at_bottom = 1'b0;
    unique case (wave_mode_sel)
      4'h0: top_val = `TWC_MAX;
      4'h4: top_val = compare_value_a_r;
      4'hC: top_val = capture_value_r;
      4'hD: top_val = `TWC_MAX;
      4'h1, 4'h2, 4'h3: begin
        kind = TWC_KIND_DUAL;
        load_at_top = 1'b1;
        top_val = (wave_mode_sel[1:0] == 2'h1) ? `TWC_TOP_8 :
          (wave_mode_sel[1:0] == 2'h2) ? `TWC_TOP_9 : `TWC_TOP_10;
      end
      4'hA, 4'hB: begin
        kind = TWC_KIND_DUAL;
        load_at_top = 1'b1;
        top_val = wave_mode_sel[0] ? compare_value_a_r : capture_value_r;
      end
      4'h8, 4'h9: begin
        kind = TWC_KIND_DUAL;
        load_at_bottom = 1'b1;
        top_val = wave_mode_sel[0] ? compare_value_a_r : capture_value_r;
      end
      4'h5, 4'h6, 4'h7: begin
        kind = TWC_KIND_FAST;
        load_at_top = 1'b1;
        top_val = (wave_mode_sel[1:0] == 2'h1) ? `TWC_TOP_8 :
          (wave_mode_sel[1:0] == 2'h2) ? `TWC_TOP_9 : `TWC_TOP_10;
      end
      4'hE, 4'hF: begin
        kind = TWC_KIND_FAST;
        load_at_top = 1'b1;
        top_val = wave_mode_sel[0] ? compare_value_a_r : capture_value_r;
      end
    endcase
  end

  assign at_top = timer_clk_en && (counter_value_r == top_val);
  assign at_bottom = timer_clk_en && (counter_value_r == `TWC_BOTTOM);
  assign ovf_at_bottom = (kind == TWC_KIND_DUAL) && at_bottom && count_down_r;
  assign ovf_at_top = (kind == TWC_KIND_FAST) && at_top;

  // ****************************************
  // Channel wave logic
  // ****************************************
  logic [1:0] wave_calc;
  logic [NP-1:0] drive_pin;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic pwm;
    assign pwm = (kind != TWC_KIND_NONPWM);
    assign match[ch] = timer_clk_en && (counter_value_r == chan_cmp[ch]);
    assign connected[ch] = (chan_act[ch] != TWC_ACT_OFF) &&
      !(pwm && chan_act[ch] == TWC_ACT_TOGGLE &&
      (!wave_mode_top_bit || ch == 1));
    always_comb begin
      wave_calc[ch] = wave_r[ch];
      unique case (kind)
        TWC_KIND_NONPWM: begin
          if (match[ch]) begin
            unique case (chan_act[ch])
              TWC_ACT_TOGGLE: wave_calc[ch] = !wave_r[ch];
              TWC_ACT_CLEAR: wave_calc[ch] = 1'b0;
              TWC_ACT_SET: wave_calc[ch] = 1'b1;
              TWC_ACT_OFF: wave_calc[ch] = wave_r[ch];
            endcase
          end
        end
        TWC_KIND_FAST: begin
          if (chan_act[ch] == TWC_ACT_TOGGLE) begin
            if (match[ch] && wave_mode_top_bit && ch == 0) begin
              wave_calc[ch] = !wave_r[ch];
            end
          end else if (chan_act[ch][1]) begin
            if (at_top) begin
              wave_calc[ch] = !chan_act[ch][0];
            end else if (match[ch]) begin
              wave_calc[ch] = chan_act[ch][0];
            end
          end
        end
        default: begin
          if (match[ch]) begin
            if (chan_act[ch] == TWC_ACT_TOGGLE) begin
              if (wave_mode_top_bit && ch == 0) begin
                wave_calc[ch] = !wave_r[ch];
              end
            end else if (chan_act[ch][1]) begin
              wave_calc[ch] = chan_act[ch][0] ^ count_down_r;
            end
          end
        end
      endcase
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_pin
    assign drive_pin[p] = connected[p / PINS_PER_CHAN] &&
      pin_enable_control_r[p] && pin_dir_r[p];
  end

  // ****************************************
  // Next state
  // ****************************************
  logic wr_hit, rd_hit;
  logic cnt_write;

  always_comb begin
    wave_compare_control_nxt = wave_compare_control_r;
    wave_mode_high_bits_nxt = wave_mode_high_bits_r;
    pin_enable_control_nxt = pin_enable_control_r;
    pin_dir_nxt = pin_dir_r;
    counter_value_nxt = counter_value_r;
    cmp_a_buf_nxt = cmp_a_buf_r;
    cmp_b_buf_nxt = cmp_b_buf_r;
    compare_value_a_nxt = compare_value_a_r;
    compare_value_b_nxt = compare_value_b_r;
    capture_value_nxt = capture_value_r;
    count_down_nxt = count_down_r;
    int_mask_nxt = int_mask_r;
    rdata_nxt = `TWC_RST_16;
    wr_hit = bus_req.wr;
    rd_hit = bus_req.rd;
    cnt_write = wr_hit && (bus_req.addr == `TWC_OFS_COUNTER);

    // Counting sequence
    if (timer_clk_en && !cnt_write) begin
      if (kind == TWC_KIND_DUAL) begin
        if (!count_down_r && counter_value_r == top_val) begin
          count_down_nxt = (top_val != `TWC_BOTTOM);
          counter_value_nxt = count_down_nxt ? counter_value_r - 16'h0001 : counter_value_r;
        end else if (count_down_r && counter_value_r == `TWC_BOTTOM) begin
          count_down_nxt = 1'b0;
          counter_value_nxt = (top_val == `TWC_BOTTOM) ? `TWC_BOTTOM : 16'h0001;
        end else begin
          counter_value_nxt = count_down_r ? counter_value_r - 16'h0001 :
            counter_value_r + 16'h0001;
        end
      end else begin
        count_down_nxt = 1'b0;
        counter_value_nxt = (counter_value_r == top_val) ? `TWC_BOTTOM :
          counter_value_r + 16'h0001;
      end
    end

    // Buffered compare load
    if ((load_at_top && at_top) || (load_at_bottom && at_bottom)) begin
      compare_value_a_nxt = cmp_a_buf_r;
      compare_value_b_nxt = cmp_b_buf_r;
    end

    if (wr_hit) begin
      unique case (bus_req.addr)
        `TWC_OFS_WAVE_CTRL: begin
          wave_compare_control_nxt = {bus_req.wdata[7:4], 2'b00, bus_req.wdata[1:0]};
        end
        `TWC_OFS_CTRL_B: begin
          wave_mode_high_bits_nxt =
            bus_req.wdata[`TWC_MODE_HI_HI:`TWC_MODE_HI_LO];
        end
        `TWC_OFS_PIN_EN: pin_enable_control_nxt = bus_req.wdata[NP-1:0];
        `TWC_OFS_COUNTER: counter_value_nxt = bus_req.wdata;
        `TWC_OFS_CMP_A: begin
          cmp_a_buf_nxt = bus_req.wdata;
          if (kind == TWC_KIND_NONPWM) begin
            compare_value_a_nxt = bus_req.wdata;
          end
        end
        `TWC_OFS_CMP_B: begin
          cmp_b_buf_nxt = bus_req.wdata;
          if (kind == TWC_KIND_NONPWM) begin
            compare_value_b_nxt = bus_req.wdata;
          end
        end
        `TWC_OFS_CAPTURE: capture_value_nxt = bus_req.wdata;
        `TWC_OFS_PIN_DIR: pin_dir_nxt = bus_req.wdata[NP-1:0];
        `TWC_OFS_INT_MASK: int_mask_nxt = bus_req.wdata[2:0];
        default: ;
      endcase
    end

    if (rd_hit) begin
      unique case (bus_req.addr)
        `TWC_OFS_WAVE_CTRL: rdata_nxt = {8'h00, wave_compare_control_r};
        `TWC_OFS_CTRL_B: rdata_nxt = {11'h000, wave_mode_high_bits_r, 3'h0};
        `TWC_OFS_PIN_EN: rdata_nxt = 16'(pin_enable_control_r);
        `TWC_OFS_COUNTER: rdata_nxt = counter_value_r;
        `TWC_OFS_CMP_A: rdata_nxt = cmp_a_buf_r;
        `TWC_OFS_CMP_B: rdata_nxt = cmp_b_buf_r;
        `TWC_OFS_CAPTURE: rdata_nxt = capture_value_r;
        `TWC_OFS_PIN_DIR: rdata_nxt = 16'(pin_dir_r);
        `TWC_OFS_INT_STATUS: rdata_nxt = {13'h0000, int_status_r};
        `TWC_OFS_INT_MASK: rdata_nxt = {13'h0000, int_mask_r};
        default: rdata_nxt = `TWC_RST_16;
      endcase
    end

    // Sticky events, set wins over write-one clear
    int_status_nxt = int_status_r;
    if (wr_hit && bus_req.addr == `TWC_OFS_INT_STATUS) begin
      int_status_nxt = int_status_r & ~bus_req.wdata[2:0];
    end
    if ((kind == TWC_KIND_NONPWM && timer_clk_en && counter_value_r == `TWC_MAX)
        || ovf_at_bottom || ovf_at_top) begin
      int_status_nxt[`TWC_INT_OVF] = 1'b1;
    end
    if (match[0]) begin
      int_status_nxt[`TWC_INT_MATCH_A] = 1'b1;
    end
    if (match[1]) begin
      int_status_nxt[`TWC_INT_MATCH_B] = 1'b1;
    end
    irq_nxt = |(int_status_nxt & int_mask_nxt);

    // Waveform and pin muxing
    wave_nxt = wave_calc;
    for (int p = 0; p < NP; p++) begin
      pin_out_nxt[p] = drive_pin[p] ? wave_calc[p / PINS_PER_CHAN] : port_data[p];
      pin_oe_n_nxt[p] = drive_pin[p] ? 1'b0 : !pin_dir_nxt[p];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wave_compare_control_r <= `TWC_RST_8;
      wave_mode_high_bits_r <= 2'b00;
      pin_enable_control_r <= '0;
      pin_dir_r <= '0;
      counter_value_r <= `TWC_RST_16;
      cmp_a_buf_r <= `TWC_RST_16;
      cmp_b_buf_r <= `TWC_RST_16;
      compare_value_a_r <= `TWC_RST_16;
      compare_value_b_r <= `TWC_RST_16;
      capture_value_r <= `TWC_RST_16;
      count_down_r <= 1'b0;
      int_status_r <= `TWC_RST_INT;
      int_mask_r <= `TWC_RST_INT;
      rdata_r <= `TWC_RST_16;
      irq_r <= 1'b0;
      wave_r <= 2'b00;
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end else begin
      wave_compare_control_r <= wave_compare_control_nxt;
      wave_mode_high_bits_r <= wave_mode_high_bits_nxt;
      pin_enable_control_r <= pin_enable_control_nxt;
      pin_dir_r <= pin_dir_nxt;
      counter_value_r <= counter_value_nxt;
      cmp_a_buf_r <= cmp_a_buf_nxt;
      cmp_b_buf_r <= cmp_b_buf_nxt;
      compare_value_a_r <= compare_value_a_nxt;
      compare_value_b_r <= compare_value_b_nxt;
      capture_value_r <= capture_value_nxt;
      count_down_r <= count_down_nxt;
      int_status_r <= int_status_nxt;
      int_mask_r <= int_mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wave_r <= wave_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign irq = irq_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign chan_a_wave_out = wave_r[0];
  assign chan_b_wave_out = wave_r[1];
endmodule

/* testbench/twc_properties.sv */
module twc_checker #(
  parameter int PINS_PER_CHAN = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire twc_pkg::twc_bus_req_type bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic timer_clk_en,
  input wire logic [2*PINS_PER_CHAN-1:0] port_data,
  input wire logic [2*PINS_PER_CHAN-1:0] pin_out,
  input wire logic [2*PINS_PER_CHAN-1:0] pin_oe_n,
  input wire logic chan_a_wave_out,
  input wire logic chan_b_wave_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import twc_pkg::*;
  localparam int W = 2*PINS_PER_CHAN;
  logic [7:0] ctl_r;
  logic [1:0] mhi_r;
  logic [W-1:0] en_r;
  logic [W-1:0] dir_r;
  logic [2:0] msk_r;
  logic [2*W+12:0] cfg;
  logic [2*W+12:0] cfg_q1_r;
  logic [2*W+12:0] cfg_q2_r;
  logic [3:0] mode;
  logic pwm;
  logic ca;
  logic cb;
  logic bres;
  logic stab;
  logic [W-1:0] drv;
  logic [W-1:0] wv;
  // ****
  // Shadow of the configuration
  // ****
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_r <= 8'h00;
      mhi_r <= 2'h0;
      en_r <= '0;
      dir_r <= '0;
      msk_r <= 3'h0;
      // Not stable until cfg_q1_r and cfg_q2_r leave their reset values
      cfg_q1_r <= '1;
      cfg_q2_r <= '1;
    end else begin
      if (bus_req.wr && bus_req.addr == 4'h0) ctl_r <= bus_req.wdata[7:0] & 8'hF3;
      if (bus_req.wr && bus_req.addr == 4'h1) mhi_r <= bus_req.wdata[4:3];
      if (bus_req.wr && bus_req.addr == 4'h2) en_r <= bus_req.wdata[W-1:0];
      if (bus_req.wr && bus_req.addr == 4'h7) dir_r <= bus_req.wdata[W-1:0];
      if (bus_req.wr && bus_req.addr == 4'h9) msk_r <= bus_req.wdata[2:0];
      cfg_q1_r <= cfg;
      cfg_q2_r <= cfg_q1_r;
    end
  end
  assign cfg = {ctl_r, mhi_r, en_r, dir_r, msk_r};
  assign stab = (cfg == cfg_q1_r) && (cfg_q1_r == cfg_q2_r);
  assign mode = {mhi_r, ctl_r[1:0]};
  assign pwm = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
  assign ca = ctl_r[7:6] != 2'h0 && !(ctl_r[7:6] == 2'h1 && pwm && !mode[3]);
  assign cb = ctl_r[5:4] != 2'h0 && !(ctl_r[5:4] == 2'h1 && pwm && !mode[3]);
  assign bres = ctl_r[5:4] == 2'h1 && pwm && mode[3];
  assign drv = {{PINS_PER_CHAN{cb}}, {PINS_PER_CHAN{ca}}} & en_r & dir_r;
  assign wv = {{PINS_PER_CHAN{chan_b_wave_out}}, {PINS_PER_CHAN{chan_a_wave_out}}};
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence rd_of(logic [3:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  pin_value_a: assert property (stab && !bres |->
    pin_out == ((drv & wv) | (~drv & $past(port_data))))
    else $error("pin value wrong");
  pin_enable_a: assert property (stab |-> pin_oe_n == ~dir_r)
    else $error("pin enable wrong");
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not idle");
  ctrl_read_a: assert property (rd_of(4'h0) |=> bus_rdata == {8'h00, $past(ctl_r)})
    else $error("control readback wrong");
  mode_read_a: assert property (rd_of(4'h1) |=>
    bus_rdata == {11'h000, $past(mhi_r), 3'h0})
    else $error("mode high readback wrong");
  set_hold_a: assert property (stab && !pwm && ctl_r[7:6] == 2'h3 |->
    !$fell(chan_a_wave_out))
    else $error("set action fell");
  clear_hold_a: assert property (stab && !pwm && ctl_r[7:6] == 2'h2 |->
    !$rose(chan_a_wave_out))
    else $error("clear action rose");
  irq_mask_a: assert property (stab && msk_r == 3'h0 |-> !irq)
    else $error("masked interrupt high");
  reset_idle_a: assert property ($fell(rst) |->
    &pin_oe_n && !chan_a_wave_out && !irq)
    else $error("not idle after reset");
endmodule

bind twc_top twc_checker #(.PINS_PER_CHAN(PINS_PER_CHAN)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .timer_clk_en(timer_clk_en), .port_data(port_data), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .chan_a_wave_out(chan_a_wave_out),
  .chan_b_wave_out(chan_b_wave_out), .irq(irq)
);

/* testbench/twc_pin_load.sv */
module twc_pin_load #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins float to the pull-up level
  assign pin_level = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule

/* testbench/tb_twc_top.sv */
module tb_twc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  twc_pkg::twc_bus_req_type bus_req = '0;
  logic timer_clk_en = 1'b0;
  logic [7:0] port_data = 8'h5A;
  logic [15:0] bus_rdata;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] pin_level;
  logic wave_a;
  logic wave_b;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  twc_top #(.PINS_PER_CHAN(4)) i_dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_clk_en(timer_clk_en), .port_data(port_data),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .chan_a_wave_out(wave_a),
    .chan_b_wave_out(wave_b), .irq(irq));
  twc_pin_load #(.W(8)) i_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level));
  // ****
  // Clock, timeout and bus tasks
  // ****
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= {a, d, 2'b10};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= {a, 16'h0000, 2'b01};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 chk(nm, exp, bus_rdata);
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys);
    timer_clk_en <= 1'b1;
    repeat (n) @(posedge clk_sys);
    timer_clk_en <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] oe, input logic [7:0] lvl);
    @(posedge clk_sys);
    #1 chk("pin_oe_n", {8'h00, oe}, {8'h00, pin_oe_n});
    chk("pin_level", {8'h00, lvl}, {8'h00, pin_level});
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", {15'h0000, e}, {15'h0000, irq});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    rchk("ctl", 4'h0, 16'h0000);
    rchk("mode_hi", 4'h1, 16'h0000);
    rchk("pin_en", 4'h2, 16'h0000);
    pins(8'hFF, 8'hFF);
    wr(4'h0, 16'h00FF);
    rchk("ctl_rsv", 4'h0, 16'h00F3);
    wr(4'h1, 16'h0018);
    rchk("mode_hi", 4'h1, 16'h0018);
    wr(4'hF, 16'hFFFF);
    rchk("unmapped", 4'hF, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    $display("test reset and registers done");
  endtask
  task automatic t_nonpwm();
    logic [1:0] code [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
    logic w [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(4'h7, 16'h000D);
    wr(4'h2, 16'h0003);
    wr(4'h4, 16'h0040);
    wr(4'h9, 16'h0002);
    pins(8'hF2, 8'hFA);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {8'h00, code[i], 6'h00});
      wr(4'h3, 16'h0040);
      ticks(1);
      pins(8'hF2, {7'h7D, w[i]});
    end
    irqchk(1'b1);
    wr(4'h9, 16'h0000);
    irqchk(1'b0);
    wr(4'h9, 16'h0002);
    irqchk(1'b1);
    wr(4'h8, 16'h0007);
    irqchk(1'b0);
    wr(4'h3, 16'hFFFF);
    ticks(1);
    rchk("ovf_max", 4'h8, 16'h0001);
    $display("test non-pwm done");
  endtask
  task automatic t_fast();
    wr(4'h8, 16'h0007);
    wr(4'h1, 16'h0008);
    wr(4'h4, 16'h0010);
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, (i == 0) ? 16'h0081 : 16'h00C1);
      wr(4'h3, 16'h00FF);
      ticks(1);
      pins(8'hF2, {7'h7D, i == 0});
      wr(4'h3, 16'h0010);
      ticks(1);
      pins(8'hF2, {7'h7D, i == 1});
    end
    rchk("ovf_top", 4'h8, 16'h0003);
    wr(4'h4, 16'h00FF);
    wr(4'h3, 16'h00FF);
    ticks(1);
    wr(4'h3, 16'h00FF);
    ticks(1);
    pins(8'hF2, 8'hFA);
    $display("test fast pwm done");
  endtask
  task automatic t_dual();
    do_reset();
    wr(4'h7, 16'h000D);
    wr(4'h2, 16'h0003);
    wr(4'h0, 16'h0081);
    wr(4'h4, 16'h00F0);
    wr(4'h3, 16'h00E0);
    ticks(46);
    pins(8'hF2, 8'hFA);
    rchk("no_ovf", 4'h8, 16'h0000);
    ticks(1);
    pins(8'hF2, 8'hFB);
    ticks(240);
    rchk("ovf_bottom", 4'h8, 16'h0007);
    ticks(239);
    pins(8'hF2, 8'hFB);
    ticks(1);
    pins(8'hF2, 8'hFA);
    $display("test dual slope done");
  endtask
  task automatic t_chan_b();
    do_reset();
    wr(4'h4, 16'h0010);
    wr(4'h5, 16'h0008);
    wr(4'h7, 16'h00F0);
    wr(4'h2, 16'h00F0);
    wr(4'h1, 16'h0010);
    wr(4'h0, 16'h0031);
    ticks(9);
    pins(8'h0F, 8'hFF);
    chk("wave_b", 16'h0001, {15'h0000, wave_b});
    ticks(16);
    pins(8'h0F, 8'h0F);
    wr(4'h5, 16'h0004);
    ticks(8);
    rchk("ovf_bot9", 4'h8, 16'h0007);
    ticks(4);
    pins(8'h0F, 8'hFF);
    wr(4'h0, 16'h0071);
    ticks(12);
    pins(8'h0F, 8'hFF);
    chk("wave_a", 16'h0001, {15'h0000, wave_a});
    $display("test channel b done");
  endtask
  initial begin
    do_reset();
    t_reset();
    t_nonpwm();
    t_fast();
    t_dual();
    t_chan_b();
    end_sim();
  end
endmodule
